// >>> hdl/string_seq_pkg.sv
// Shared constants and types for the move-string sequencer.
// Assumes a 32-bit core with 32 general registers and a byte-wide memory port.
package string_seq_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int WORD_W = 32;          // Width of a general register.
  localparam int ADDR_W = 32;          // Width of an effective address.
  localparam int BYTE_W = 8;           // Width of one memory byte.
  localparam int REG_INDEX_W = 5;      // Selects one of 32 general registers.
  localparam int LEN_W = 7;            // Byte length, up to 127.
  localparam int COUNT_FIELD_W = 5;    // Immediate byte-count field width.
  localparam int LANE_W = 2;           // Byte position inside a register.

  // ----------------------------------------------------------------
  // Field positions and fixed values
  // ----------------------------------------------------------------
  // The count field sits in bits 25..31 of the exception register in
  // big-endian numbering, which is bits 6..0 of the vector.
  localparam int EXC_COUNT_LSB = 0;
  localparam logic [LEN_W-1:0] IMM_ZERO_LEN = 7'h20;        // Zero field means 32 bytes.
  localparam logic [LANE_W-1:0] LAST_LANE = 2'h3;           // Fourth byte of a register.
  localparam logic [LEN_W-1:0] LEN_ONE = 7'h01;
  localparam logic [REG_INDEX_W-1:0] REG_STEP = 5'h01;

  // ----------------------------------------------------------------
  // Buffer shape
  // ----------------------------------------------------------------
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_WIDTH = 8;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [WORD_W-1:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 32'h0000_0000;
  localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [LEN_W-1:0] LEN_ZERO = 7'h00;
  localparam logic [REG_INDEX_W-1:0] REG_ZERO = 5'h00;
  localparam logic [LANE_W-1:0] LANE_ZERO = 2'h0;

  // The four move-string instructions.
  typedef enum logic [1:0] {
    load_string_imm,
    load_string_indexed,
    store_string_imm,
    store_string_indexed
  } string_op_t;

endpackage : string_seq_pkg

// >>> hdl/byte_stream_if.sv
// Valid/ready byte stream used between the sequencer and its buffer.
// Assumes sender and receiver share one clock.
`timescale 1ns/10ps
interface byte_stream_if #(parameter int W = 8);
  logic valid;          // Sender offers data.
  logic ready;          // Receiver accepts data.
  logic [W-1:0] data;   // The offered byte.
  modport sender (output valid, output data, input ready);
  modport receiver (input valid, input data, output ready);
endinterface : byte_stream_if

// >>> hdl/byte_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes a single clock and synchronous active-high reset.
`timescale 1ns/10ps
module byte_fifo
  import string_seq_pkg::*;
#(
  parameter int WIDTH = FIFO_WIDTH,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  byte_stream_if.receiver fill,
  byte_stream_if.sender drain
);

  // ----------------------------------------------------------------
  // Storage and pointers
  // ----------------------------------------------------------------
  localparam int PTR_W = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH];     // Data entries.
  logic [PTR_W-1:0] wr_ptr;            // Next entry to write.
  logic [PTR_W-1:0] rd_ptr;            // Next entry to read.
  logic [PTR_W:0] count;               // Entries held.
  logic [PTR_W-1:0] next_wr_ptr;
  logic [PTR_W-1:0] next_rd_ptr;
  logic [PTR_W:0] next_count;
  logic do_push;
  logic do_pop;

  // Full and empty come straight from the count, so they never lie.
  assign fill.ready = (count != (PTR_W+1)'(DEPTH));
  assign drain.valid = (count != '0);
  assign drain.data = store[rd_ptr];

  // Pointer and count update.
  always_comb begin
    do_push = fill.valid && fill.ready;
    do_pop = drain.valid && drain.ready;
    next_wr_ptr = do_push ? PTR_W'(wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr = do_pop ? PTR_W'(rd_ptr + 1'b1) : rd_ptr;
    next_count = count;
    if (do_push && !do_pop) begin
      next_count = (PTR_W+1)'(count + 1'b1);
    end else if (do_pop && !do_push) begin
      next_count = (PTR_W+1)'(count - 1'b1);
    end
  end

  // Registers; the array itself needs no reset.
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // Entry write.
  always_ff @(posedge clk) begin
    if (do_push) begin
      store[wr_ptr] <= fill.data;
    end
  end

endmodule : byte_fifo

// >>> hdl/string_setup.sv
// Computes effective address and byte length of a move-string command.
// Assumes register contents for the base and offset are supplied by the core.
`timescale 1ns/10ps
module string_setup
  import string_seq_pkg::*;
(
  input wire string_op_t op,
  input wire logic [REG_INDEX_W-1:0] base_reg_index,
  input wire logic [WORD_W-1:0] base_value,
  input wire logic [WORD_W-1:0] offset_value,
  input wire logic [COUNT_FIELD_W-1:0] byte_count_field,
  input wire logic [WORD_W-1:0] fixed_point_exception_reg,
  output logic [ADDR_W-1:0] effective_address,
  output logic [LEN_W-1:0] length
);

  // Pure combinational decode; the sequencer latches the results.
  always_comb begin
    logic indexed;
    logic [ADDR_W-1:0] base;
    indexed = (op == load_string_indexed) || (op == store_string_indexed);
    base = (base_reg_index == REG_ZERO) ? ADDR_ZERO : base_value;
    effective_address = indexed ? ADDR_W'(base + offset_value) : base;
    if (indexed) begin
      length = fixed_point_exception_reg[EXC_COUNT_LSB +: LEN_W];
    end else if (byte_count_field == '0) begin
      length = IMM_ZERO_LEN;
    end else begin
      length = LEN_W'(byte_count_field);
    end
  end

endmodule : string_setup

// >>> hdl/load_store_string_sequencer.sv
// Move-string sequencer of the load/store path.
// Assumes a byte-wide req/ack memory port and a register file with one
// write port and one read port whose data is valid while the read
// enable is high.
//
// Summary of operation
// - Any byte address allowed, never an alignment fault.
// - Indexed zero length changes no state.
// - Base inside destination range is simply loaded.
// - Immediate length is field, zero means 32.
// - Indexed length comes from exception register bits.
// - Address is base or zero, plus index.
// - Load writes ceil(length/4) registers from destination.
// - Load fetches consecutive ascending bytes from address.
// - Load fills MSB first, wraps 31 to 0.
// - Partial last loaded register is zero padded.
// - Indexed zero-length load transfers no bytes.
// - Store reads ceil(length/4) registers from source.
// - Store writes consecutive ascending bytes from address.
// - Store takes MSB first, wraps 31 to 0.
`timescale 1ns/10ps
module load_store_string_sequencer
  import string_seq_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire string_op_t cmd_op,
  input wire logic [REG_INDEX_W-1:0] cmd_reg_index,
  input wire logic [REG_INDEX_W-1:0] base_reg_index,
  input wire logic [WORD_W-1:0] base_value,
  input wire logic [WORD_W-1:0] offset_value,
  input wire logic [COUNT_FIELD_W-1:0] byte_count_field,
  input wire logic [WORD_W-1:0] fixed_point_exception_reg,
  output logic done,
  output logic mem_req,
  output logic mem_we,
  output logic [ADDR_W-1:0] mem_addr,
  output logic [BYTE_W-1:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [BYTE_W-1:0] mem_rdata,
  output logic rf_we,
  output logic [REG_INDEX_W-1:0] rf_waddr,
  output logic [WORD_W-1:0] rf_wdata,
  output logic rf_re,
  output logic [REG_INDEX_W-1:0] rf_raddr,
  input wire logic [WORD_W-1:0] rf_rdata
);

  // ----------------------------------------------------------------
  // Types and state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {st_idle, st_run} seq_state_t;

  seq_state_t state;                    // Sequencer phase.
  seq_state_t next_state;
  string_op_t op;                       // Instruction being executed.
  string_op_t next_op;
  logic [ADDR_W-1:0] effective_address; // Latched start address.
  logic [ADDR_W-1:0] next_effective_address;
  logic [LEN_W-1:0] len;                // Latched byte length.
  logic [LEN_W-1:0] next_len;
  logic [LEN_W-1:0] issued;             // Bytes fetched (load) or buffered (store).
  logic [LEN_W-1:0] next_issued;
  logic [LEN_W-1:0] drained;            // Bytes packed (load) or written (store).
  logic [LEN_W-1:0] next_drained;
  logic [REG_INDEX_W-1:0] reg_index;    // Current general register.
  logic [REG_INDEX_W-1:0] next_reg_index;
  logic [LANE_W-1:0] lane;              // Byte position in the current register.
  logic [LANE_W-1:0] next_lane;
  logic [WORD_W-1:0] word;              // Load accumulator or store source word.
  logic [WORD_W-1:0] next_word;
  logic have_word;                      // Store source word is held.
  logic next_have_word;

  // Next values of the registered outputs.
  logic next_cmd_ready;
  logic next_done;
  logic next_mem_req;
  logic next_mem_we;
  logic [ADDR_W-1:0] next_mem_addr;
  logic [BYTE_W-1:0] next_mem_wdata;
  logic next_rf_we;
  logic [REG_INDEX_W-1:0] next_rf_waddr;
  logic [WORD_W-1:0] next_rf_wdata;
  logic next_rf_re;
  logic [REG_INDEX_W-1:0] next_rf_raddr;

  // Results of the command decode.
  logic [ADDR_W-1:0] setup_address;
  logic [LEN_W-1:0] setup_len;

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  byte_stream_if #(.W(FIFO_WIDTH)) push_s ();
  byte_stream_if #(.W(FIFO_WIDTH)) pop_s ();

  // The buffer decouples the memory side from the register side; a full
  // buffer holds back memory requests on loads and byte pushes from the source word on stores.
  byte_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) buffer (
    .clk(clk),
    .rst(rst),
    .fill(push_s),
    .drain(pop_s)
  );

  string_setup setup (
    .op(cmd_op),
    .base_reg_index(base_reg_index),
    .base_value(base_value),
    .offset_value(offset_value),
    .byte_count_field(byte_count_field),
    .fixed_point_exception_reg(fixed_point_exception_reg),
    .effective_address(setup_address),
    .length(setup_len)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // One process computes every next value; loads and stores each run two
  // independent halves, one on either side of the buffer.
  always_comb begin
    logic is_load;
    logic last_byte;
    logic [4:0] shift;
    logic [WORD_W-1:0] merged;
    is_load = (op == load_string_imm) || (op == load_string_indexed);
    last_byte = 1'b0;
    shift = {~lane, 3'b000};
    merged = WORD_ZERO;
    next_state = state;
    next_op = op;
    next_effective_address = effective_address;
    next_len = len;
    next_issued = issued;
    next_drained = drained;
    next_reg_index = reg_index;
    next_lane = lane;
    next_word = word;
    next_have_word = have_word;
    next_done = 1'b0;
    next_mem_req = mem_req;
    next_mem_we = mem_we;
    next_mem_addr = mem_addr;
    next_mem_wdata = mem_wdata;
    next_rf_we = 1'b0;
    next_rf_waddr = rf_waddr;
    next_rf_wdata = rf_wdata;
    next_rf_re = 1'b0;
    next_rf_raddr = rf_raddr;
    push_s.valid = 1'b0;
    push_s.data = BYTE_ZERO;
    pop_s.ready = 1'b0;
    case (state)
      st_idle: begin
        // Latch the decoded command; nothing moves until the next cycle.
        if (cmd_valid) begin
          next_state = st_run;
          next_op = cmd_op;
          next_effective_address = setup_address;
          next_len = setup_len;
          next_issued = LEN_ZERO;
          next_drained = LEN_ZERO;
          next_reg_index = cmd_reg_index;
          next_lane = LANE_ZERO;
          next_word = WORD_ZERO;
          next_have_word = 1'b0;
        end
      end
      st_run: begin
        if (drained == len && !mem_req) begin
          // A zero length lands here at once, so no byte and no register moves.
          next_state = st_idle;
          next_done = 1'b1;
        end else if (is_load) begin
          // Memory side: one byte at a time at ascending addresses, only
          // while the buffer has room for the byte being asked for.
          if (mem_req) begin
            if (mem_ack) begin
              next_mem_req = 1'b0;
              push_s.valid = 1'b1;
              push_s.data = mem_rdata;
              next_issued = LEN_W'(issued + LEN_ONE);
            end
          end else if (issued != len && push_s.ready) begin
            next_mem_req = 1'b1;
            next_mem_we = 1'b0;
            next_mem_addr = ADDR_W'(effective_address + ADDR_W'(issued));
          end
          // Register side: pack bytes from the most significant end.
          if (pop_s.valid) begin
            pop_s.ready = 1'b1;
            merged = word | (WORD_W'(pop_s.data) << shift);
            last_byte = (LEN_W'(drained + LEN_ONE) == len);
            next_drained = LEN_W'(drained + LEN_ONE);
            if (lane == LAST_LANE || last_byte) begin
              // Unfilled low bytes stay zero from the cleared accumulator.
              next_rf_we = 1'b1;
              next_rf_waddr = reg_index;
              next_rf_wdata = merged;
              next_reg_index = REG_INDEX_W'(reg_index + REG_STEP);
              next_word = WORD_ZERO;
              next_lane = LANE_ZERO;
            end else begin
              next_word = merged;
              next_lane = LANE_W'(lane + 1'b1);
            end
          end
        end else begin
          // Register side: fetch a source word, then feed its bytes in.
          if (rf_re) begin
            next_word = rf_rdata;
            next_have_word = 1'b1;
            next_reg_index = REG_INDEX_W'(reg_index + REG_STEP);
          end else if (!have_word && issued != len) begin
            next_rf_re = 1'b1;
            next_rf_raddr = reg_index;
          end else if (have_word && push_s.ready) begin
            push_s.valid = 1'b1;
            push_s.data = BYTE_W'(word >> shift);
            last_byte = (LEN_W'(issued + LEN_ONE) == len);
            next_issued = LEN_W'(issued + LEN_ONE);
            if (lane == LAST_LANE || last_byte) begin
              next_have_word = 1'b0;
              next_lane = LANE_ZERO;
            end else begin
              next_lane = LANE_W'(lane + 1'b1);
            end
          end
          // Memory side: write each buffered byte at the next address.
          if (mem_req) begin
            if (mem_ack) begin
              next_mem_req = 1'b0;
              next_drained = LEN_W'(drained + LEN_ONE);
            end
          end else if (pop_s.valid) begin
            pop_s.ready = 1'b1;
            next_mem_req = 1'b1;
            next_mem_we = 1'b1;
            next_mem_wdata = pop_s.data;
            next_mem_addr = ADDR_W'(effective_address + ADDR_W'(drained));
          end
        end
      end
      default: begin
        next_state = st_idle;
      end
    endcase
    // Ready is registered, so it rises in the same cycle as done.
    next_cmd_ready = (next_state == st_idle);
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  // Every output is a flip-flop and has a defined value from reset on.
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= st_idle;
      op <= load_string_imm;
      effective_address <= ADDR_ZERO;
      len <= LEN_ZERO;
      issued <= LEN_ZERO;
      drained <= LEN_ZERO;
      reg_index <= REG_ZERO;
      lane <= LANE_ZERO;
      word <= WORD_ZERO;
      have_word <= 1'b0;
      cmd_ready <= 1'b1;
      done <= 1'b0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= ADDR_ZERO;
      mem_wdata <= BYTE_ZERO;
      rf_we <= 1'b0;
      rf_waddr <= REG_ZERO;
      rf_wdata <= WORD_ZERO;
      rf_re <= 1'b0;
      rf_raddr <= REG_ZERO;
    end else begin
      state <= next_state;
      op <= next_op;
      effective_address <= next_effective_address;
      len <= next_len;
      issued <= next_issued;
      drained <= next_drained;
      reg_index <= next_reg_index;
      lane <= next_lane;
      word <= next_word;
      have_word <= next_have_word;
      cmd_ready <= next_cmd_ready;
      done <= next_done;
      mem_req <= next_mem_req;
      mem_we <= next_mem_we;
      mem_addr <= next_mem_addr;
      mem_wdata <= next_mem_wdata;
      rf_we <= next_rf_we;
      rf_waddr <= next_rf_waddr;
      rf_wdata <= next_rf_wdata;
      rf_re <= next_rf_re;
      rf_raddr <= next_rf_raddr;
    end
  end

endmodule : load_store_string_sequencer

// >>> sim/string_seq_chk.sv
// Checker for the move-string sequencer, bound to its top module.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module string_seq_chk
  import string_seq_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire string_op_t cmd_op,
  input wire logic [REG_INDEX_W-1:0] cmd_reg_index,
  input wire logic [REG_INDEX_W-1:0] base_reg_index,
  input wire logic [WORD_W-1:0] base_value,
  input wire logic [WORD_W-1:0] offset_value,
  input wire logic [COUNT_FIELD_W-1:0] byte_count_field,
  input wire logic [WORD_W-1:0] fixed_point_exception_reg,
  input wire logic done,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic [BYTE_W-1:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic rf_we,
  input wire logic [REG_INDEX_W-1:0] rf_waddr,
  input wire logic [WORD_W-1:0] rf_wdata,
  input wire logic rf_re,
  input wire logic [REG_INDEX_W-1:0] rf_raddr
);
  // ----------------------------------------------------------------
  // Tracking of the command in flight
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] exp_addr; // Address the next memory request must carry.
  logic [LEN_W-1:0] n_len; // Byte length of the command in flight.
  logic [REG_INDEX_W-1:0] first_reg; // First register of the run.
  logic [5:0] moves; // Register reads or writes seen so far.
  logic is_store; // The command in flight writes memory.
  logic take, idx;
  logic [5:0] nr; // Registers the command must touch.
  assign take = cmd_valid && cmd_ready;
  assign idx = (cmd_op == load_string_indexed) || (cmd_op == store_string_indexed);
  assign nr = 6'(({1'b0, n_len} + 8'h03) >> 2);

  // Latch the command at acceptance, then follow its progress.
  always_ff @(posedge clk) begin
    if (rst) begin
      exp_addr <= ADDR_ZERO;
      n_len <= LEN_ZERO;
      first_reg <= REG_ZERO;
      moves <= 6'h00;
      is_store <= 1'b0;
    end else if (take) begin
      exp_addr <= (base_reg_index == REG_ZERO ? ADDR_ZERO : base_value) + (idx ? offset_value : ADDR_ZERO);
      n_len <= idx ? fixed_point_exception_reg[LEN_W-1:0]
                   : (byte_count_field == 5'h00 ? IMM_ZERO_LEN : {2'h0, byte_count_field});
      first_reg <= cmd_reg_index;
      moves <= 6'h00;
      is_store <= (cmd_op == store_string_imm) || (cmd_op == store_string_indexed);
    end else begin
      if (mem_req && mem_ack) begin
        exp_addr <= exp_addr + 32'h1;
      end
      if (rf_we || rf_re) begin
        moves <= moves + 6'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  addr_track_a: assert property (mem_req |-> mem_addr == exp_addr && mem_we == is_store)
    else $error("memory request address or direction off");
  req_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_wdata))
    else $error("memory request dropped or changed before ack");
  req_gap_a: assert property (mem_req && mem_ack |=> !mem_req)
    else $error("memory request not released after ack");
  done_pulse_a: assert property (done |=> !done)
    else $error("done longer than one cycle");
  busy_after_take_a: assert property (take |=> !cmd_ready && !done)
    else $error("sequencer idle right after taking a command");
  reg_count_a: assert property (done |-> moves == nr)
    else $error("wrong number of register accesses");
  write_index_a: assert property (rf_we |-> rf_waddr == first_reg + moves[4:0])
    else $error("register write index out of sequence");
  read_index_a: assert property (rf_re |-> rf_raddr == first_reg + moves[4:0])
    else $error("register read index out of sequence");
  pad_zero_a: assert property (rf_we && moves + 6'h01 == nr && n_len[1:0] != 2'h0 |->
    (rf_wdata << {n_len[1:0], 3'h0}) == WORD_ZERO)
    else $error("partial last register not zero padded");
  zero_len_a: assert property (take && idx && fixed_point_exception_reg[LEN_W-1:0] == LEN_ZERO |->
    ##1 (!mem_req && !rf_we && !rf_re) [*2])
    else $error("zero length command moved data");
endmodule : string_seq_chk

bind load_store_string_sequencer string_seq_chk u_string_seq_chk (.*);

// >>> sim/string_mem_model.sv
// Model of the memory port and general register file facing the sequencer.
// Assumes memory sees only the low eight address bits, so it wraps at 256.
`timescale 1ns/10ps
module string_mem_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] delay,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic mem_ack,
  output logic [7:0] mem_rdata,
  input wire logic rf_we,
  input wire logic [4:0] rf_waddr,
  input wire logic [31:0] rf_wdata,
  input wire logic rf_re,
  input wire logic [4:0] rf_raddr,
  output logic [31:0] rf_rdata
);
  logic [7:0] mem [0:255]; // Byte memory.
  logic [31:0] regs [0:31]; // General registers.
  logic [1:0] cnt; // Wait cycles spent on the pending request.

  // Start with distinct contents so misplaced bytes show.
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i * 37 + 11);
    for (int i = 0; i < 32; i++) regs[i] = {4{8'(i * 13 + 5)}} ^ 32'h1234_5678;
  end

  // Answer after delay cycles; read data is scrambled outside the ack cycle.
  always @(posedge clk) begin
    if (rst) begin
      mem_ack <= 1'b0;
      cnt <= 2'h0;
      mem_rdata <= 8'h00;
    end else begin
      mem_rdata <= ~mem_rdata;
      if (mem_req && mem_ack) begin
        mem_ack <= 1'b0;
        cnt <= 2'h0;
        if (mem_we) mem[mem_addr[7:0]] <= mem_wdata;
      end else if (mem_req && cnt >= delay) begin
        mem_ack <= 1'b1;
        mem_rdata <= mem[mem_addr[7:0]];
      end else if (mem_req) begin
        cnt <= cnt + 2'h1;
      end
    end
    if (rf_we) regs[rf_waddr] <= rf_wdata;
  end

  // Read data is only good while the read strobe is up.
  assign rf_rdata = rf_re ? regs[rf_raddr] : ~regs[rf_raddr];
endmodule : string_mem_model

// >>> sim/load_store_string_sequencer_tb_top.sv
// Self-checking bench for the move-string sequencer.
// Assumes the partner model holds memory and registers.
`timescale 1ns/10ps
module load_store_string_sequencer_tb_top import string_seq_pkg::*;;
  logic clk, rst, cmd_valid, done, cmd_ready, mem_req, mem_we, mem_ack, rf_we, rf_re;
  string_op_t cmd_op;
  logic [4:0] cmd_reg_index, base_reg_index, byte_count_field, rf_waddr, rf_raddr;
  logic [31:0] base_value, offset_value, fixed_point_exception_reg, mem_addr, rf_wdata, rf_rdata, seed;
  logic [7:0] mem_wdata, mem_rdata;
  logic [1:0] delay; // Memory wait cycles per request.
  logic [7:0] exp_mem [0:255]; // Expected memory.
  logic [31:0] exp_rf [0:31]; // Expected registers.
  int fails, cmp_count;

  load_store_string_sequencer u_load_store_string_sequencer (.*);
  string_mem_model u_string_mem_model (.*);

  // 40 MHz clock.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Pseudo-random source; a fixed start keeps runs repeatable.
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  // Apply the expected effect of one move to the expected arrays.
  function automatic void expect_move(input string_op_t op, input logic [4:0] r, input logic [31:0] ea,
      input logic [6:0] n);
    logic [4:0] k;
    logic [7:0] a;
    for (int i = 0; i < n; i++) begin
      k = r + 5'(i / 4);
      a = ea[7:0] + 8'(i);
      if (op == load_string_imm || op == load_string_indexed) begin
        if (i % 4 == 0) exp_rf[k] = WORD_ZERO;
        exp_rf[k][31 - 8 * (i % 4) -: 8] = exp_mem[a];
      end else begin
        exp_mem[a] = exp_rf[k][31 - 8 * (i % 4) -: 8];
      end
    end
  endfunction : expect_move

  // Compare one stored value.
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  // Report and end the run.
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  // Issue one command, wait for done under a bound, then compare all state.
  task automatic run_cmd(input string_op_t op, input logic [4:0] r, input logic [4:0] b, input logic [6:0] n,
      input logic [1:0] dly);
    logic [31:0] bv, ov, xr;
    logic ix;
    int t;
    ix = (op == load_string_indexed) || (op == store_string_indexed);
    bv = lfsr_next(seed);
    ov = lfsr_next(bv);
    seed = lfsr_next(ov);
    xr = {seed[31:7], ix ? n : seed[6:0]};
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_reg_index <= r;
    base_reg_index <= b;
    base_value <= bv;
    offset_value <= ov;
    byte_count_field <= ix ? seed[4:0] : n[4:0];
    fixed_point_exception_reg <= xr;
    delay <= dly;
    @(posedge clk);
    cmd_valid <= 1'b0;
    expect_move(op, r, (b == 5'h00 ? 32'h0 : bv) + (ix ? ov : 32'h0),
      ix ? n : (n[4:0] == 5'h00 ? IMM_ZERO_LEN : {2'h0, n[4:0]}));
    t = 0;
    do begin
      @(negedge clk);
      t++;
    end while (done !== 1'b1 && t < 3000);
    if (t >= 3000) begin
      fails++;
      stop_test();
    end
    for (int i = 0; i < 32; i++) check(u_string_mem_model.regs[i], exp_rf[i], "register");
    for (int i = 0; i < 256; i++) check({24'h0, u_string_mem_model.mem[i]}, {24'h0, exp_mem[i]}, "byte");
  endtask : run_cmd

  // Reset, corner cases, then random commands.
  initial begin
    seed = 32'h0000_002f;
    fails = 0;
    cmp_count = 0;
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = load_string_imm;
    {cmd_reg_index, base_reg_index, byte_count_field} = 15'h0000;
    {base_value, offset_value, fixed_point_exception_reg} = 96'h0;
    delay = 2'h0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 256; i++) exp_mem[i] = u_string_mem_model.mem[i];
    for (int i = 0; i < 32; i++) exp_rf[i] = u_string_mem_model.regs[i];
    run_cmd(load_string_imm, 5'h1e, 5'h00, 7'h00, 2'h0);
    run_cmd(store_string_imm, 5'h1f, 5'h03, 7'h00, 2'h3);
    run_cmd(load_string_indexed, 5'h04, 5'h05, 7'h00, 2'h1);
    run_cmd(store_string_indexed, 5'h04, 5'h05, 7'h00, 2'h0);
    run_cmd(load_string_indexed, 5'h1d, 5'h1e, 7'h7f, 2'h2);
    run_cmd(load_string_imm, 5'h07, 5'h08, 7'h05, 2'h0);
    run_cmd(store_string_indexed, 5'h02, 5'h01, 7'h06, 2'h1);
    for (int k = 0; k < 40; k++) begin
      seed = lfsr_next(seed);
      run_cmd(string_op_t'(seed[1:0]), seed[6:2], seed[11:7], seed[18:12], seed[20:19]);
    end
    stop_test();
  end
endmodule : load_store_string_sequencer_tb_top
